// *** lpi_pkg.sv ***
// Notes on behaviour
// - Passive modes send dithered one-bit colour values
// - Active modes: blue LSB on line zero
// - Active 16/18 bpp use 16/18 lines
// - Active 24 bpp: 8 lines, three clocks
// - Active data is direct intensity, never dithered
// - Passive mono carries up to 8-bit grey
// - 24-bit active; dual colour eight bits per half
// - Drive 4, 8, 16 or 18 lines
// - Smart reads release lines 7..0 to panel
// - Pixel clock clocks data; smart write strobe
// - Line clock: line end or horizontal sync
// - Smart: line clock selects command or data
// - Frame clock: frame start or vertical sync
// - Smart reads: frame clock is read strobe
// - Bias toggles passive; active data enable
// - Chip select driven for smart panels only
// - Mono single scan uses lines 3..0
// - Double pixel select uses lines 7..0
// - Colour single scan uses lines 7..0
// - Dual scan: top low, bottom above

`default_nettype none

package lpi_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W     = 18;  // Panel data lines
    localparam int PIX_W      = 24;  // Incoming pixel word
    localparam int RD_W       = 8;   // Smart read width
    localparam int BLUE_LSB   = 0;   // Blue byte of pixel word
    localparam int GREEN_LSB  = 8;   // Green byte
    localparam int RED_LSB    = 16;  // Red byte
    localparam int TOP_LSB    = 0;   // Passive top-half bits
    localparam int BOT_LSB    = 8;   // Passive bottom-half bits

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ     = 25000;  // Controller clock
    localparam int PCLK_HALF_NS = 80;    // Pixel clock half period
    localparam int PCLK_HALF_CYC =
        (PCLK_HALF_NS * CLK_KHZ) / 1000000;
    localparam int STROBE_HALVES = 3;    // Smart strobe low time
    localparam logic [1:0] LAST_BEAT_24 = 2'h2; // Third clock

    // ------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LPI_PASSIVE = 2'b00,
        LPI_ACTIVE  = 2'b01,
        LPI_SMART   = 2'b10
    } lpi_panel_e;

    typedef enum logic [1:0] {
        LPI_D16 = 2'b00,
        LPI_D18 = 2'b01,
        LPI_D24 = 2'b10
    } lpi_depth_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_STREAM = 3'b001,
        ST_SETUP  = 3'b010,
        ST_STROBE = 3'b011,
        ST_HOLD   = 3'b100
    } lpi_state_e;

endpackage : lpi_pkg

`default_nettype wire

// *** lpi_pin_stage.sv ***
`timescale 1ns/1ps
`default_nettype none

module lpi_pin_stage #(
    parameter int PCLK_HALF = lpi_pkg::PCLK_HALF_CYC,
    parameter int STROBE_HP = lpi_pkg::STROBE_HALVES
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // Mode selection
    input  wire logic [1:0]                  panel_type,
    input  wire logic                        color_panel,
    input  wire logic                        dual_scan,
    input  wire logic                        double_pixel_select,
    input  wire logic [1:0]                  active_depth,
    input  wire logic                        stream_en,
    // Pixel stream
    input  wire logic                        pix_valid,
    input  wire logic [lpi_pkg::PIX_W-1:0]   pix_data,
    input  wire logic                        pix_line_end,
    input  wire logic                        pix_frame_start,
    output logic                             pix_ack,
    // Smart panel transactions
    input  wire logic                        sm_req,
    input  wire logic                        sm_cmd,
    input  wire logic                        sm_read,
    input  wire logic [lpi_pkg::DATA_W-1:0]  sm_wdata,
    output logic                             sm_done,
    output logic [lpi_pkg::RD_W-1:0]         sm_rdata,
    // Panel pins
    output logic [lpi_pkg::DATA_W-1:0]       panel_data_lines_o,
    output logic [lpi_pkg::DATA_W-1:0]       panel_data_lines_oe_n,
    input  wire logic [lpi_pkg::RD_W-1:0]    panel_data_lines_i,
    output logic                             pixel_clock_wr,
    output logic                             line_clock_cmd_select,
    output logic                             frame_clock_read_strobe,
    output logic                             ac_bias,
    output logic                             chip_select,
    input  wire logic                        refresh_sync_i,
    output logic                             refresh_sync
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (PCLK_HALF < 1 || PCLK_HALF > 255) begin : g_bad_half
        $error("PCLK_HALF out of range");
    end
    if (STROBE_HP < 1 || STROBE_HP > 15) begin : g_bad_strobe
        $error("STROBE_HP out of range");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]                 div_ff;       // Half-period counter
    logic                       hp_en;        // Half-period tick
    lpi_pkg::lpi_state_e        state_ff;     // Sequencer state
    lpi_pkg::lpi_state_e        nxt_state;    // Next state
    logic [1:0]                 beat_ff;      // 24 bpp sub-clock
    logic [3:0]                 strb_ff;      // Strobe half count
    logic                       pclk_ff;      // Pixel clock level
    logic                       loaded_ff;    // Data on lines
    logic                       take;         // Pixel beat taken
    logic                       last_beat;    // Beat ends pixel
    logic [lpi_pkg::DATA_W-1:0] nxt_data;     // Mapped lines
    logic [lpi_pkg::DATA_W-1:0] data_ff;      // Data line drive
    logic [lpi_pkg::DATA_W-1:0] oe_n_ff;      // Line enables
    logic                       lclk_ff;      // Line clock pin
    logic                       fclk_ff;      // Frame clock pin
    logic                       bias_ff;      // Bias pin
    logic                       cs_ff;        // Chip select pin
    logic                       ack_ff;       // Pixel ack pulse
    logic                       done_ff;      // Smart done pulse
    logic [lpi_pkg::RD_W-1:0]   rdata_ff;     // Read data
    logic [lpi_pkg::RD_W-1:0]   rd_s1_ff;     // Read sync stage 1
    logic [lpi_pkg::RD_W-1:0]   rd_s2_ff;     // Read sync stage 2
    logic [lpi_pkg::RD_W-1:0]   rd_s3_ff;     // Read sync stage 3
    logic                       vs_s1_ff;     // Sync stage 1
    logic                       vs_s2_ff;     // Sync stage 2
    logic                       vs_s3_ff;     // Sync stage 3
    logic                       vs_ff;        // Accepted level
    logic                       is_smart;     // Smart panel mode
    logic                       is_active;    // Active panel mode
    logic [7:0]                 blu;          // Pixel blue byte
    logic [7:0]                 grn;          // Pixel green byte
    logic [7:0]                 red;          // Pixel red byte
    logic [7:0]                 top;          // Passive top bits
    logic [7:0]                 bot;          // Passive bottom bits

    assign is_smart  = (panel_type == lpi_pkg::LPI_SMART);
    assign is_active = (panel_type == lpi_pkg::LPI_ACTIVE);
    assign blu = pix_data[lpi_pkg::BLUE_LSB +: 8];
    assign grn = pix_data[lpi_pkg::GREEN_LSB +: 8];
    assign red = pix_data[lpi_pkg::RED_LSB +: 8];
    assign top = pix_data[lpi_pkg::TOP_LSB +: 8];
    assign bot = pix_data[lpi_pkg::BOT_LSB +: 8];

    // ------------------------------------------------------------
    // Pixel clock divider
    // ------------------------------------------------------------
    // Counts controller clocks into half periods
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 8'h00;
        end else if (hp_en) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    assign hp_en = (div_ff == 8'(PCLK_HALF - 1));

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Three stages; a change counts when stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vs_s1_ff <= 1'b0;
            vs_s2_ff <= 1'b0;
            vs_s3_ff <= 1'b0;
            vs_ff    <= 1'b0;
            rd_s1_ff <= 8'h00;
            rd_s2_ff <= 8'h00;
            rd_s3_ff <= 8'h00;
        end else begin
            vs_s1_ff <= refresh_sync_i;
            vs_s2_ff <= vs_s1_ff;
            vs_s3_ff <= vs_s2_ff;
            rd_s1_ff <= panel_data_lines_i;
            rd_s2_ff <= rd_s1_ff;
            rd_s3_ff <= rd_s2_ff;
            // Refresh sync only meaningful for smart panels
            if (vs_s2_ff == vs_s3_ff) begin
                vs_ff <= vs_s3_ff & is_smart;
            end
        end
    end

    // ------------------------------------------------------------
    // Data line mapping
    // ------------------------------------------------------------
    // Places one beat of the current pixel on the lines
    always_comb begin
        nxt_data = 18'h0_0000;
        if (is_active) begin
            // Direct intensity, no dithering
            unique case (active_depth)
                lpi_pkg::LPI_D18: begin
                    nxt_data = {red[7:2], grn[7:2], blu[7:2]};
                end
                lpi_pkg::LPI_D24: begin
                    // Blue, green, red over three clocks
                    if (beat_ff == 2'h0) begin
                        nxt_data = {10'h000, blu};
                    end else if (beat_ff == 2'h1) begin
                        nxt_data = {10'h000, grn};
                    end else begin
                        nxt_data = {10'h000, red};
                    end
                end
                default: begin
                    nxt_data = {2'h0, red[7:3], grn[7:2], blu[7:3]};
                end
            endcase
        end else if (!color_panel) begin
            // Monochrome: one grey bit per line per clock
            if (dual_scan) begin
                nxt_data = {10'h000, bot[3:0], top[3:0]};
            end else if (double_pixel_select) begin
                nxt_data = {10'h000, top};
            end else begin
                nxt_data = {14'h0000, top[3:0]};
            end
        end else if (dual_scan) begin
            // Colour dual scan: eight bits per half
            nxt_data = {2'h0, bot, top};
        end else begin
            nxt_data = {10'h000, top};
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign last_beat = !(is_active
        && active_depth == lpi_pkg::LPI_D24)
        || beat_ff == lpi_pkg::LAST_BEAT_24;
    // Beat taken on a falling half, or into empty lines with clock low
    assign take = (state_ff == lpi_pkg::ST_STREAM) && hp_en
        && (pclk_ff || !loaded_ff) && pix_valid;

    // Next state on half-period ticks
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            lpi_pkg::ST_IDLE: begin
                if (hp_en && is_smart && sm_req) begin
                    nxt_state = lpi_pkg::ST_SETUP;
                end else if (hp_en && !is_smart && stream_en) begin
                    nxt_state = lpi_pkg::ST_STREAM;
                end
            end
            lpi_pkg::ST_STREAM: begin
                // Leave only with the clock low
                if (hp_en && !pclk_ff && (is_smart || !stream_en)) begin
                    nxt_state = lpi_pkg::ST_IDLE;
                end
            end
            lpi_pkg::ST_SETUP: begin
                if (hp_en) begin
                    nxt_state = lpi_pkg::ST_STROBE;
                end
            end
            lpi_pkg::ST_STROBE: begin
                if (hp_en && strb_ff == 4'(STROBE_HP - 1)) begin
                    nxt_state = lpi_pkg::ST_HOLD;
                end
            end
            lpi_pkg::ST_HOLD: begin
                if (hp_en) begin
                    nxt_state = lpi_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = lpi_pkg::ST_IDLE;
            end
        endcase
    end

    // State, beat and strobe counters
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= lpi_pkg::ST_IDLE;
            beat_ff  <= 2'h0;
            strb_ff  <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff != lpi_pkg::ST_STREAM) begin
                beat_ff <= 2'h0;
            end else if (take) begin
                beat_ff <= last_beat ? 2'h0 : beat_ff + 2'h1;
            end
            if (state_ff != lpi_pkg::ST_STROBE) begin
                strb_ff <= 4'h0;
            end else if (hp_en) begin
                strb_ff <= strb_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Data lines and their enables
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_ff   <= 18'h0_0000;
            oe_n_ff   <= 18'h0_0000;
            loaded_ff <= 1'b0;
        end else if (state_ff == lpi_pkg::ST_SETUP) begin
            if (sm_read) begin
                // Hand lines 7..0 to the panel
                oe_n_ff <= 18'h0_00FF;
                data_ff <= 18'h0_0000;
            end else begin
                oe_n_ff <= 18'h0_0000;
                data_ff <= sm_wdata;
            end
        end else if (state_ff == lpi_pkg::ST_IDLE) begin
            // Lines driven low while quiet
            oe_n_ff   <= 18'h0_0000;
            data_ff   <= 18'h0_0000;
            loaded_ff <= 1'b0;
        end else if (state_ff == lpi_pkg::ST_STREAM && hp_en && (pclk_ff || !loaded_ff)) begin
            // Falling half: present the next beat or starve
            loaded_ff <= pix_valid;
            if (pix_valid) begin
                data_ff <= nxt_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Pixel clock and write strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pclk_ff <= 1'b0;
        end else if (is_smart) begin
            // Write strobe, active low
            pclk_ff <= !(state_ff == lpi_pkg::ST_STROBE && !sm_read);
        end else if (state_ff != lpi_pkg::ST_STREAM) begin
            pclk_ff <= 1'b0;
        end else if (hp_en) begin
            // Rises only over loaded data; pauses when starved
            pclk_ff <= pclk_ff ? 1'b0 : loaded_ff;
        end
    end

    // ------------------------------------------------------------
    // Line clock, frame clock, bias and chip select
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lclk_ff <= 1'b0;
            fclk_ff <= 1'b0;
            bias_ff <= 1'b0;
            cs_ff   <= 1'b0;
        end else if (is_smart) begin
            // Transaction select: low command, high data
            if (state_ff == lpi_pkg::ST_SETUP) begin
                lclk_ff <= !sm_cmd;
            end
            // Read strobe, active low
            fclk_ff <= !(state_ff == lpi_pkg::ST_STROBE && sm_read);
            cs_ff   <= (state_ff != lpi_pkg::ST_IDLE);
            bias_ff <= 1'b0;
        end else begin
            cs_ff <= 1'b0;
            if (state_ff != lpi_pkg::ST_STREAM) begin
                lclk_ff <= 1'b0;
                fclk_ff <= 1'b0;
                if (is_active) begin
                    bias_ff <= 1'b0;
                end
            end else if (hp_en && (pclk_ff || !loaded_ff)) begin
                // Marks held for the beat they travel with
                if (pix_valid) begin
                    lclk_ff <= pix_line_end && last_beat;
                    fclk_ff <= pix_frame_start && beat_ff == 2'h0;
                end else begin
                    lclk_ff <= 1'b0;
                    fclk_ff <= 1'b0;
                end
                if (is_active) begin
                    // Data enable for the panel latch
                    bias_ff <= pix_valid;
                end else if (pix_valid && pix_frame_start) begin
                    // Polarity swap once per frame
                    bias_ff <= !bias_ff;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake answers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff   <= 1'b0;
            done_ff  <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff  <= take && last_beat;
            done_ff <= (state_ff == lpi_pkg::ST_HOLD) && hp_en;
            // Capture once the read lines have settled
            if (state_ff == lpi_pkg::ST_HOLD && sm_read && hp_en
                && rd_s2_ff == rd_s3_ff) begin
                rdata_ff <= rd_s3_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pix_ack                 = ack_ff;
    assign sm_done                 = done_ff;
    assign sm_rdata                = rdata_ff;
    assign panel_data_lines_o      = data_ff;
    assign panel_data_lines_oe_n   = oe_n_ff;
    assign pixel_clock_wr          = pclk_ff;
    assign line_clock_cmd_select   = lclk_ff;
    assign frame_clock_read_strobe = fclk_ff;
    assign ac_bias                 = bias_ff;
    assign chip_select             = cs_ff;
    assign refresh_sync            = vs_ff;

endmodule // lpi_pin_stage

`default_nettype wire

// *** lpi_pin_stage_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpi_chk #(
    parameter int PCLK_HALF = 1,
    parameter int STROBE_HP = 3
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [1:0]  panel_type,
    input wire logic        color_panel,
    input wire logic        dual_scan,
    input wire logic        double_pixel_select,
    input wire logic [1:0]  active_depth,
    input wire logic        sm_cmd,
    input wire logic        sm_read,
    input wire logic        sm_done,
    input wire logic        pix_ack,
    input wire logic [17:0] panel_data_lines_o,
    input wire logic [17:0] panel_data_lines_oe_n,
    input wire logic        pixel_clock_wr,
    input wire logic        line_clock_cmd_select,
    input wire logic        frame_clock_read_strobe,
    input wire logic        chip_select
);
    // ----------------------------------------
    // Strobe low-time counter
    // ----------------------------------------
    logic [7:0] low_cnt_ff;  // Cycles the write strobe has been low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_ff <= 8'h00;
        end else begin
            low_cnt_ff <= pixel_clock_wr ? 8'h00 : low_cnt_ff + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_cs_smart_only: assert property (panel_type != 2'h2 && $stable(panel_type) |-> !chip_select)
        else $error("chip select outside smart mode");
    chk_read_release: assert property (chip_select && sm_read |-> &panel_data_lines_oe_n[7:0])
        else $error("low lines driven during read");
    chk_cmd_select: assert property (chip_select |-> line_clock_cmd_select == !sm_cmd)
        else $error("command select wrong");
    chk_rd_strobe_idle: assert property (chip_select && !sm_read |-> frame_clock_read_strobe)
        else $error("read strobe on a write");
    chk_strobe_len: assert property ($rose(pixel_clock_wr) && chip_select
        |-> low_cnt_ff == PCLK_HALF * STROBE_HP)
        else $error("write strobe width wrong");
    chk_done_bound: assert property ($rose(chip_select) |-> ##[4:12] sm_done)
        else $error("transaction did not finish");
    chk_mono_lines: assert property (pix_ack && panel_type == 2'h0 && !color_panel && !dual_scan
        && !double_pixel_select |-> panel_data_lines_o[17:4] == 14'h0)
        else $error("mono single scan uses high lines");
    chk_d24_lines: assert property (pix_ack && panel_type == 2'h1 && active_depth == 2'h2
        |-> panel_data_lines_o[17:8] == 10'h0)
        else $error("24 bpp uses high lines");
    cover property (sm_done && sm_read);
    cover property (pix_ack && active_depth == 2'h2);
    cover property ($fell(frame_clock_read_strobe) && chip_select);
endmodule // lpi_chk
`default_nettype wire

// *** lpi_panel_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpi_panel_model (
    // Strobes from the block
    input  wire logic       cs,
    input  wire logic       rd_n,
    // Read value and pins
    input  wire logic [7:0] rd_val,
    output logic      [7:0] dq,
    output var logic        vsync
);
    logic seen;  // Read strobe seen in this select
    initial vsync = 1'b0;
    // Refresh sync, free running
    always #160 vsync = ~vsync;
    // Drive lines once the read strobe fell, until deselect
    always @(cs or rd_n) begin
        if (!cs) begin
            seen = 1'b0;
        end else if (!rd_n) begin
            seen = 1'b1;
        end
    end
    // Released lines show the inverse, never a stale copy
    assign dq = seen ? rd_val : ~rd_val;
endmodule // lpi_panel_model
`default_nettype wire

// *** lpi_pin_stage_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpi_pin_stage_tb;
    logic        clk = 0, rstn = 0, color_panel = 0, dual_scan = 0, double_pixel_select = 0;
    logic        stream_en = 0, pix_valid = 0, pix_line_end = 0, pix_frame_start = 0;
    logic        sm_req = 0, sm_cmd = 0, sm_read = 0, pix_ack, sm_done, pclk, lclk, fclk;
    logic        ac_bias, chip_select, vsync, refresh_sync;
    logic [1:0]  panel_type = 0, active_depth = 0;
    logic [23:0] pix_data = 0;
    logic [17:0] sm_wdata = 0, dl_o, dl_oe_n;
    logic [7:0]  rd_val = 8'h00, sm_rdata, pin_in;
    int          fails = 0, checks_done = 0;
    always #20 clk = ~clk;
    lpi_pin_stage #(.PCLK_HALF(2), .STROBE_HP(3)) dut (.clk(clk), .rstn(rstn),
        .panel_type(panel_type), .color_panel(color_panel), .dual_scan(dual_scan),
        .double_pixel_select(double_pixel_select), .active_depth(active_depth),
        .stream_en(stream_en), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_line_end(pix_line_end), .pix_frame_start(pix_frame_start), .pix_ack(pix_ack),
        .sm_req(sm_req), .sm_cmd(sm_cmd), .sm_read(sm_read), .sm_wdata(sm_wdata),
        .sm_done(sm_done), .sm_rdata(sm_rdata), .panel_data_lines_o(dl_o),
        .panel_data_lines_oe_n(dl_oe_n), .panel_data_lines_i(pin_in), .pixel_clock_wr(pclk),
        .line_clock_cmd_select(lclk), .frame_clock_read_strobe(fclk), .ac_bias(ac_bias),
        .chip_select(chip_select), .refresh_sync_i(vsync), .refresh_sync(refresh_sync));
    lpi_panel_model u_panel (.cs(chip_select), .rd_n(fclk), .rd_val(rd_val), .dq(pin_in),
        .vsync(vsync));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic tick; @(posedge clk); #1; endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Expected line pattern for one beat in the current mode
    function automatic logic [17:0] exp_lines(input logic [23:0] p, input int b);
        if (panel_type == 2'h1) begin
            if (active_depth == 2'h2) return {10'h0, p[8*b +: 8]};
            if (active_depth == 2'h1) return {p[23:18], p[15:10], p[7:2]};
            return {2'h0, p[23:19], p[15:10], p[7:3]};
        end
        if (color_panel) return dual_scan ? {2'h0, p[15:0]} : {10'h0, p[7:0]};
        if (dual_scan) return {10'h0, p[11:8], p[3:0]};
        return double_pixel_select ? {10'h0, p[7:0]} : {14'h0, p[3:0]};
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic send_pixel(input logic [23:0] p, input logic fs, input logic le);
        logic [20:0] q[$];
        int n, nb, acks;
        logic prev;
        nb = (panel_type == 2'h1 && active_depth == 2'h2) ? 3 : 1;
        pix_data = p; pix_frame_start = fs; pix_line_end = le; pix_valid = 1;
        prev = pclk; n = 0; acks = 0;
        // Ack comes at the last load; that beat's rising clock follows it
        while (q.size() < nb && n < 60) begin
            tick; n++;
            if (pix_ack === 1'b1) begin pix_valid = 0; acks++; end
            if (pclk === 1'b1 && prev === 1'b0)
                q.push_back({ac_bias & (panel_type == 2'h1), fclk, lclk, dl_o});
            prev = pclk;
        end
        pix_valid = 0;
        if (n >= 60) fails++;
        check(acks, 1);
        for (int b = 0; b < nb; b++)
            check((q.size() > b) ? {3'h0, q[b]} : 24'hff_ffff,
                {3'h0, panel_type == 2'h1, fs && b == 0, le && b == nb - 1, exp_lines(p, b)});
    endtask
    task automatic run_mode(input logic [1:0] pt, input logic c, d, dp, input logic [1:0] dep);
        panel_type = pt; color_panel = c; dual_scan = d; double_pixel_select = dp;
        active_depth = dep; stream_en = 1;
        send_pixel(24'h5a_c396, 1'b1, 1'b0);
        send_pixel(24'ha5_3c69, 1'b0, 1'b1);
        stream_en = 0;
        repeat (4) tick;
        $display("mode %0h/%0b%0b%0b/%0h done", pt, c, d, dp, dep);
    endtask
    task automatic smart_xfer(input logic cmd, rd, input logic [17:0] wd, input logic [7:0] rv);
        int n;
        sm_cmd = cmd; sm_read = rd; sm_wdata = wd; rd_val = rv; sm_req = 1; n = 0;
        while (sm_done !== 1'b1 && n < 40) begin
            tick; n++;
            if (!rd && chip_select === 1'b1 && pclk === 1'b0) check({6'h0, dl_o}, {6'h0, wd});
        end
        sm_req = 0;
        if (n >= 40) fails++;
        if (rd) check({16'h0, sm_rdata}, {16'h0, rv});
        repeat (2) tick;
        $display("smart cmd=%0b rd=%0b done", cmd, rd);
    endtask
    task automatic refuse;
        panel_type = 2'h0; sm_req = 1;
        repeat (12) begin
            tick;
            check({22'h0, chip_select, sm_done}, 24'h00_0000);
        end
        check({23'h0, refresh_sync}, 24'h00_0000);
        sm_req = 0;
        tick;
        $display("refusal done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1;
        tick;
        refuse;
        run_mode(2'h0, 0, 0, 0, 2'h0);
        run_mode(2'h0, 0, 0, 1, 2'h0);
        run_mode(2'h0, 0, 1, 0, 2'h0);
        run_mode(2'h0, 1, 0, 0, 2'h0);
        run_mode(2'h0, 1, 1, 0, 2'h0);
        for (int d = 0; d < 3; d++) run_mode(2'h1, 0, 0, 0, d[1:0]);
        panel_type = 2'h2;
        repeat (3) tick;
        smart_xfer(1, 0, 18'h2_a5c3, 8'h00);
        smart_xfer(0, 0, 18'h1_5a3c, 8'h00);
        smart_xfer(1, 1, 18'h0_0000, 8'h96);
        smart_xfer(0, 1, 18'h0_0000, 8'h3c);
        summarize;
    end
    initial begin
        #(20000 * 40);
        fails++;
        summarize;
    end
endmodule // lpi_pin_stage_tb
bind lpi_pin_stage lpi_chk #(.PCLK_HALF(PCLK_HALF), .STROBE_HP(STROBE_HP)) u_chk (
    .clk(clk), .rstn(rstn), .panel_type(panel_type), .color_panel(color_panel),
    .dual_scan(dual_scan), .double_pixel_select(double_pixel_select),
    .active_depth(active_depth), .sm_cmd(sm_cmd), .sm_read(sm_read), .sm_done(sm_done),
    .pix_ack(pix_ack), .panel_data_lines_o(panel_data_lines_o),
    .panel_data_lines_oe_n(panel_data_lines_oe_n), .pixel_clock_wr(pixel_clock_wr),
    .line_clock_cmd_select(line_clock_cmd_select),
    .frame_clock_read_strobe(frame_clock_read_strobe), .chip_select(chip_select));
`default_nettype wire
